// ==== sms_pkg.sv ====
// Shared constants and types for the serial peripheral block.
package sms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and field positions.
  localparam logic [7:0] ADDR_DATA   = 8'h21;
  localparam logic [7:0] ADDR_CTRL   = 8'h22;
  localparam logic [7:0] ADDR_STAT   = 8'h23;

  localparam int CTL_IRQ_EN  = 7;
  localparam int CTL_PER_EN  = 6;
  localparam int CTL_RATE_HI = 5;
  localparam int CTL_MASTER  = 4;
  localparam int CTL_CLOCK_POLARITY    = 3;
  localparam int CTL_CLOCK_PHASE    = 2;
  localparam int CTL_RATE_B1 = 1;
  localparam int CTL_RATE_B0 = 0;

  localparam int STA_DONE    = 7;
  localparam int STA_WRITE_COLLISION_FLAG    = 6;
  localparam int STA_OVR     = 5;
  localparam int STA_MODE_FAULT_FLAG    = 4;
  localparam int STA_RSVD    = 3;
  localparam int STA_SOD     = 2;
  localparam int STA_SSM     = 1;
  localparam int STA_SSI     = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Rate codes {rate_div_high, rate_div_low} and half periods in cycles.
  localparam logic [2:0] RATE_DIV4   = 3'h4;
  localparam logic [2:0] RATE_DIV8   = 3'h0;
  localparam logic [2:0] RATE_DIV16  = 3'h1;
  localparam logic [2:0] RATE_DIV32  = 3'h6;
  localparam logic [2:0] RATE_DIV64  = 3'h2;
  localparam logic [2:0] RATE_DIV128 = 3'h3;

  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  // Sixteen clock transitions make one byte.
  localparam logic [3:0] LAST_EDGE   = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01
  } sms_state_type;

endpackage

// ==== sms_rate_div.sv ====
// Serial clock divider: one tick per half period of the serial clock.
`timescale 1ns/1ps
module sms_rate_div
  import sms_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  sms_rate_if.div   rif
);

  logic [6:0] cnt_r;
  logic [6:0] half;
  logic       tick_r;

  // Unlisted codes fall back to the slowest rate.
  always_comb begin
    case (rif.rate)
      RATE_DIV4:  half = HALF_DIV4;
      RATE_DIV8:  half = HALF_DIV8;
      RATE_DIV16: half = HALF_DIV16;
      RATE_DIV32: half = HALF_DIV32;
      RATE_DIV64: half = HALF_DIV64;
      default:    half = HALF_DIV128;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || !rif.run) begin
      cnt_r  <= 7'h00;
      tick_r <= 1'b0;
    end else if (cnt_r == half - 7'h01) begin
      cnt_r  <= 7'h00;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 7'h01;
      tick_r <= 1'b0;
    end
  end

  assign rif.tick = tick_r;

endmodule

// ==== sms_rate_if.sv ====
// Link between the transfer engine and the serial clock divider.
`timescale 1ns/1ps
interface sms_rate_if;
  logic       run;
  logic [2:0] rate;
  logic       tick;
  modport div  (input run, input rate, output tick);
  modport user (output run, output rate, input tick);
endinterface

// ==== sms_slave_model.sv ====
// Behavioural external slave that answers the block while it is master.
`timescale 1ns/1ps
module sms_slave_model (
  input  wire logic       clk_in,
  input  wire logic       frame_rst_in,
  input  wire logic       clock_polarity_in,
  input  wire logic       clock_phase_in,
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic [7:0] tx_in,
  output logic            miso_out,
  output logic      [7:0] rx_out
);
  logic       sck_r;
  logic       mosi_r;
  logic [4:0] edges_r;
  logic [4:0] pos;

  // Runs with the master's polarity and phase, and is the only slave.
  // The master moves its data line in the same cycle as its clock, so the
  // level held one cycle before the seen edge is the one at the edge.
  always_ff @(posedge clk_in) begin
    mosi_r <= mosi_in;
    if (frame_rst_in) begin
      sck_r   <= clock_polarity_in;
      edges_r <= 5'h00;
      rx_out  <= 8'h00;
    end else if (sck_in != sck_r) begin
      sck_r   <= sck_in;
      edges_r <= edges_r + 5'h01;
      if ((edges_r[0] ^ clock_phase_in) == 1'b0) begin
        rx_out <= {rx_out[6:0], mosi_r};
      end
    end
  end

  assign pos = (edges_r == 5'h00) ? 5'h00 : edges_r - {4'h0, clock_phase_in};
  // Past the last bit the line carries the inverse of bit 0, which keeps a stale
  // level from passing for good data.
  assign miso_out = pos[4] ? ~tx_in[0] : tx_in[3'h7 - pos[3:1]];
endmodule

// ==== sms_spi.sv ====
// Serial peripheral: registers, master/slave shift engine, pins and flags.
// What this block does
// - Done, fault, overrun share one enabled interrupt.
// - Enable clears at reset and on fault.
// - Master drives clock, swaps data pins; fault clears.
// - Master clock is CPU clock over 4..128.
// - Polarity bit sets serial clock idle level.
// - Phase picks first or second capture edge.
// - Done flag sets; status then data clears.
// - Data writes ignored while done flag unread.
// - Data write mid-transfer flags collision, discarded.
// - Byte arriving while done set flags overrun.
// - Select low in master flags mode fault.
// - Output disable releases the serial data output.
// - Wait mode unaffected; enabled events wake.
// - Halt freezes registers; extra bytes flag overrun.
// - Only slave done wakes from halt.
// - Slave without new data echoes received byte.
// - Soft select bit replaces the select pin.
// - Received byte goes to buffer; writes hit shifter.
// - Bytes shift most significant bit first.
`timescale 1ns/1ps
module sms_spi
  import sms_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            irq_out,
  output logic            wake_out,
  input  wire logic       halt_in,
  input  wire logic       sel_n_in,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_n_out,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe_n_out,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe_n_out
);

  sms_rate_if rif ();

  logic [7:0]    ctrl_r;
  logic          sod_r, ssm_r, ssi_r;
  logic          transfer_done_flag_r, write_collision_flag_r, ovr_r, mode_fault_flag_r;
  logic          arm_r, marm_r, halt_sel_r;
  logic [7:0]    shift_r, rxbuf_r;
  logic          samp_r, sck_r, prev_sck_r;
  logic [3:0]    edge_r;
  sms_state_type state_r;
  logic          sck_oe_n_r, mosi_oe_n_r, miso_oe_n_r;
  logic          irq_r, wake_r;

  logic       en, master, clock_phase, sel_n, slave_live, busy;
  logic       m_ev, s_ev, ev, sample_edge, in_bit, done, start;
  logic       wr_data, wr_ctrl, wr_stat, rd_data, rd_stat;
  logic       data_ok, write_collision_flag_set, done_clr, mode_fault_flag_set;
  logic [7:0] rx_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and derived conditions.
  assign en     = ctrl_r[CTL_PER_EN];
  assign master = ctrl_r[CTL_MASTER];
  assign clock_phase   = ctrl_r[CTL_CLOCK_PHASE];
  assign sel_n  = ssm_r ? ssi_r : sel_n_in;

  // A slave keeps shifting through halt only if selected at halt entry,
  // so the finished byte can wake the part.
  assign slave_live = en && !master && !sel_n
                      && (!halt_in || halt_sel_r);
  assign busy = (state_r == ST_SHIFT) || (slave_live && edge_r != 4'h0);

  always_comb begin
    wr_data = 1'b0;
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    rd_data = 1'b0;
    rd_stat = 1'b0;
    if (addr_in == ADDR_DATA) begin
      wr_data = wr_in && !halt_in;
      rd_data = rd_in && !halt_in;
    end else if (addr_in == ADDR_CTRL) begin
      wr_ctrl = wr_in && !halt_in;
    end else if (addr_in == ADDR_STAT) begin
      wr_stat = wr_in && !halt_in;
      rd_stat = rd_in && !halt_in;
    end
  end

  assign done_clr = arm_r && (wr_data || rd_data);
  assign data_ok  = wr_data && !busy
                    && (!transfer_done_flag_r || arm_r);
  assign write_collision_flag_set = wr_data && busy;
  assign start    = data_ok && en && master;
  assign mode_fault_flag_set = en && master && !sel_n;

  assign rif.run  = (state_r == ST_SHIFT) && !halt_in;
  assign rif.rate = {ctrl_r[CTL_RATE_HI], ctrl_r[CTL_RATE_B1],
                     ctrl_r[CTL_RATE_B0]};

  sms_rate_div u_div (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .rif    (rif.div)
  );

  // Inputs are synchronous, so the previous pin level gives the slave edge.
  assign m_ev = (state_r == ST_SHIFT) && rif.tick;
  assign s_ev = slave_live && (sck_in != prev_sck_r);
  assign ev   = m_ev || s_ev;
  assign sample_edge = (edge_r[0] == clock_phase);
  assign in_bit  = master ? miso_in : mosi_in;
  assign done    = ev && (edge_r == LAST_EDGE);
  assign rx_byte = clock_phase ? {shift_r[6:0], in_bit} : {shift_r[6:0], samp_r};

  ////////////////////////////////////////////////////////////////////////////
  // Control register.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= CTRL_RESET;
    end else if (mode_fault_flag_set) begin
      ctrl_r[CTL_PER_EN] <= 1'b0;
      ctrl_r[CTL_MASTER] <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata_in;
      // Enable and master cannot be set while a fault stands unacknowledged.
      if (mode_fault_flag_r && !marm_r) begin
        ctrl_r[CTL_PER_EN] <= 1'b0;
        ctrl_r[CTL_MASTER] <= 1'b0;
      end
    end
  end

  // Writable status bits; the reserved bit is not stored and reads zero.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sod_r <= STAT_RESET[STA_SOD];
      ssm_r <= STAT_RESET[STA_SSM];
      ssi_r <= STAT_RESET[STA_SSI];
    end else if (wr_stat) begin
      sod_r <= wdata_in[STA_SOD];
      ssm_r <= wdata_in[STA_SSM];
      ssi_r <= wdata_in[STA_SSI];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a set always wins over a clear in the same cycle.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      transfer_done_flag_r <= STAT_RESET[STA_DONE];
      write_collision_flag_r <= STAT_RESET[STA_WRITE_COLLISION_FLAG];
      ovr_r  <= STAT_RESET[STA_OVR];
      mode_fault_flag_r <= STAT_RESET[STA_MODE_FAULT_FLAG];
    end else begin
      if (done && (!transfer_done_flag_r || done_clr)) begin
        transfer_done_flag_r <= 1'b1;
      end else if (done_clr) begin
        transfer_done_flag_r <= 1'b0;
      end
      if (write_collision_flag_set) begin
        write_collision_flag_r <= 1'b1;
      end else if (done_clr) begin
        write_collision_flag_r <= 1'b0;
      end
      if (done && transfer_done_flag_r && !done_clr) begin
        ovr_r <= 1'b1;
      end else if (rd_stat) begin
        ovr_r <= 1'b0;
      end
      if (mode_fault_flag_set) begin
        mode_fault_flag_r <= 1'b1;
      end else if (wr_ctrl && marm_r) begin
        mode_fault_flag_r <= 1'b0;
      end
    end
  end

  // Clearing sequences: a status read (for the fault, also a status write) arms,
  // the next data access or control write completes the clear.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      arm_r  <= 1'b0;
      marm_r <= 1'b0;
    end else begin
      if (rd_stat && (transfer_done_flag_r || write_collision_flag_r)) begin
        arm_r <= 1'b1;
      end else if (wr_data || rd_data || !(transfer_done_flag_r || write_collision_flag_r)) begin
        arm_r <= 1'b0;
      end
      if ((rd_stat || wr_stat) && mode_fault_flag_r) begin
        marm_r <= 1'b1;
      end else if (wr_ctrl || !mode_fault_flag_r) begin
        marm_r <= 1'b0;
      end
    end
  end

  // Select level captured as halt begins.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      halt_sel_r <= 1'b0;
    end else if (!halt_in) begin
      halt_sel_r <= !sel_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine. The shifter keeps the last received byte, so a slave
  // with no fresh data echoes it back.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      edge_r  <= 4'h0;
      shift_r <= 8'h00;
      samp_r  <= 1'b0;
      rxbuf_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (mode_fault_flag_set || done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (data_ok) begin
        shift_r <= wdata_in;
        edge_r  <= 4'h0;
      end else if (ev) begin
        edge_r <= edge_r + 4'h1;
        if (done) begin
          shift_r <= rx_byte;
          if (!transfer_done_flag_r || done_clr) begin
            rxbuf_r <= rx_byte;
          end
        end else if (sample_edge) begin
          samp_r <= in_bit;
        end else if (edge_r != 4'h0 || !clock_phase) begin
          shift_r <= {shift_r[6:0], samp_r};
        end
      end else if ((!master && !slave_live && !halt_in) || mode_fault_flag_set) begin
        edge_r <= 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins. Enables are low while this block drives the pin.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_r      <= 1'b0;
      prev_sck_r <= 1'b0;
    end else begin
      prev_sck_r <= sck_in;
      if (state_r == ST_IDLE) begin
        sck_r <= ctrl_r[CTL_CLOCK_POLARITY];
      end else if (m_ev) begin
        sck_r <= !sck_r;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_oe_n_r  <= 1'b1;
      mosi_oe_n_r <= 1'b1;
      miso_oe_n_r <= 1'b1;
    end else begin
      sck_oe_n_r  <= !(en && master);
      mosi_oe_n_r <= !(en && master && !sod_r);
      miso_oe_n_r <= !(en && !master && !sel_n && !sod_r);
    end
  end

  assign sck_out       = sck_r;
  assign sck_oe_n_out  = sck_oe_n_r;
  assign mosi_out      = shift_r[7];
  assign mosi_oe_n_out = mosi_oe_n_r;
  assign miso_out      = shift_r[7];
  assign miso_oe_n_out = miso_oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read port, interrupt and halt wakeup.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in && addr_in == ADDR_DATA) begin
      rdata_out <= rxbuf_r;
    end else if (rd_in && addr_in == ADDR_CTRL) begin
      rdata_out <= ctrl_r;
    end else if (rd_in && addr_in == ADDR_STAT) begin
      rdata_out <= {transfer_done_flag_r, write_collision_flag_r, ovr_r, mode_fault_flag_r, 1'b0, sod_r, ssm_r,
                    ssi_r};
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Collision is a status flag only and never interrupts.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r  <= ctrl_r[CTL_IRQ_EN]
                && (transfer_done_flag_r || mode_fault_flag_r || ovr_r);
      wake_r <= halt_in && ctrl_r[CTL_IRQ_EN] && transfer_done_flag_r
                && !master;
    end
  end

  assign irq_out  = irq_r;
  assign wake_out = wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  irq_gate_a: assert property (!ctrl_r[CTL_IRQ_EN] |=> !irq_out)
    else $error("interrupt raised while disabled");
  fault_drop_a: assert property (mode_fault_flag_set |=>
    !ctrl_r[CTL_PER_EN] && !ctrl_r[CTL_MASTER] && mode_fault_flag_r)
    else $error("mode fault did not drop enable and master");
  rate_fast_a: assert property ((start && rif.rate == RATE_DIV4)
    |-> ##[30:40] done) else $error("fastest rate byte late");
  clk_idle_a: assert property (state_r == ST_IDLE |=>
    sck_out == $past(ctrl_r[CTL_CLOCK_POLARITY]))
    else $error("serial clock idle level wrong");
  blocked_wr_a: assert property ((wr_data && transfer_done_flag_r && !arm_r && !busy)
    |=> $stable(shift_r)) else $error("data write not ignored");
  collide_a: assert property (write_collision_flag_set |=> write_collision_flag_r)
    else $error("write collision not flagged");
  overrun_a: assert property ((done && transfer_done_flag_r && !done_clr)
    |=> ovr_r && $stable(rxbuf_r)) else $error("overrun not flagged");
  done_buf_a: assert property ((done && !transfer_done_flag_r)
    |=> transfer_done_flag_r && rxbuf_r == $past(rx_byte))
    else $error("received byte not buffered");
  out_off_a: assert property (sod_r |=>
    mosi_oe_n_out && miso_oe_n_out) else $error("output not released");
  halt_wake_a: assert property ((halt_in && mode_fault_flag_r && !transfer_done_flag_r)
    |=> !wake_out) else $error("fault woke from halt");

  master_byte_c: cover property (start ##[1:300] done);
  slave_byte_c:  cover property (slave_live && done);
  fault_c:       cover property (mode_fault_flag_set);
  overrun_c:     cover property (done && transfer_done_flag_r && !done_clr);

endmodule

// ==== sms_spi_tb.sv ====
// Self-checking bench for the serial peripheral as bus master and as slave.
`timescale 1ns/1ps
module sms_spi_tb
  import sms_pkg::*;
;
  logic       clk_in;
  logic       rst_in;
  logic [7:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic       halt_in;
  logic       sel_n_in;
  logic       sck_in;
  logic       mosi_in;
  logic       clock_polarity;
  logic       clock_phase;
  logic       frm_rst;
  logic [7:0] tx_byte;
  wire  [7:0] rdata_out;
  wire  [7:0] rx_byte;
  wire        irq_out;
  wire        sck_out;
  wire        sck_oe_n_out;
  wire        mosi_out;
  wire        mosi_oe_n_out;
  wire        miso_in;
  wire        miso_out;
  wire        miso_oe_n_out;
  wire        wake_out;
  int         n_errors;
  int         tests_run;

  sms_spi uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .wake_out(wake_out),
    .halt_in(halt_in), .sel_n_in(sel_n_in), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe_n_out(mosi_oe_n_out),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe_n_out(miso_oe_n_out));

  sms_slave_model partner (.clk_in(clk_in), .frame_rst_in(frm_rst),
    .clock_polarity_in(clock_polarity), .clock_phase_in(clock_phase), .sck_in(sck_out), .mosi_in(mosi_out),
    .tx_in(tx_byte), .miso_out(miso_in), .rx_out(rx_byte));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 v = rdata_out;
  endtask

  function automatic logic [7:0] half_of(input logic [2:0] code);
    case (code)
      3'h4:    return 8'h02;
      3'h0:    return 8'h04;
      3'h1:    return 8'h08;
      3'h6:    return 8'h10;
      3'h2:    return 8'h20;
      default: return 8'h40;
    endcase
  endfunction

  // Waits for the interrupt and times one half period of the serial clock.
  task automatic wait_done(input logic [7:0] half);
    int   n;
    int   cnt;
    int   t0;
    logic s;
    #1;
    cnt = 0;
    t0  = 0;
    s   = sck_out;
    for (n = 0; n < 5000 && irq_out !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
      if (sck_out !== s) begin
        s = sck_out;
        cnt++;
        if (cnt == 3) chk("half_period", 8'(n - t0), half);
        t0 = n;
      end
    end
    if (n >= 5000) begin
      n_errors++;
      summarize();
    end
  endtask

  // Bench as master for the slave checks: three cycles per half period,
  // data set up ahead and the slave output read before each sampling edge.
  task automatic sxfer(input logic [7:0] b, output logic [7:0] got);
    got = 8'h00;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_in);
      if (!k[0]) mosi_in <= b[7 - k / 2];
      tick(1);
      if (k[0] == clock_phase) got = {got[6:0], miso_out};
      @(posedge clk_in);
      sck_in <= ~sck_in;
    end
    tick(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] codes [6];
    logic [7:0] v;
    logic [7:0] dat;
    logic       bad;
    codes = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    n_errors = 0;
    tests_run = 0;
    rst_in = 1'b1;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    halt_in = 1'b0;
    sel_n_in = 1'b1;
    sck_in = 1'b0;
    mosi_in = 1'b0;
    clock_polarity = 1'b0;
    clock_phase = 1'b0;
    frm_rst = 1'b1;
    tx_byte = 8'h00;
    void'($urandom(87566));
    tick(3);
    rst_in <= 1'b0;
    frm_rst <= 1'b0;
    rd(ADDR_CTRL, v);
    chk("ctrl_reset", v & 8'hF0, 8'h00);
    rd(ADDR_STAT, v);
    chk("stat_reset", v, STAT_RESET);
    rd(8'h30, v);
    chk("unmapped", v, 8'h00);
    chk("sck_oe_reset", {7'h00, sck_oe_n_out}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_STAT, 8'h03);
      clock_polarity <= 1'($urandom);
      clock_phase <= 1'($urandom);
      tick(1);
      wr(ADDR_CTRL, {2'b11, codes[i][2], 1'b1, clock_polarity, clock_phase, codes[i][1:0]});
      tick(3);
      chk("sck_idle", {7'h00, sck_out}, {7'h00, clock_polarity});
      chk("sck_drive", {7'h00, sck_oe_n_out}, 8'h00);
      tx_byte <= 8'($urandom);
      frm_rst <= 1'b1;
      tick(1);
      frm_rst <= 1'b0;
      dat = 8'($urandom);
      wr(ADDR_DATA, dat);
      wr(ADDR_DATA, ~dat);
      wait_done(half_of(codes[i]));
      tick(2);
      chk("irq_done", {7'h00, irq_out}, 8'h01);
      chk("sent_byte", rx_byte, dat);
      wr(ADDR_DATA, 8'h5A);
      bad = 1'b0;
      repeat (12) begin
        @(posedge clk_in);
        #1;
        if (sck_out !== clock_polarity) bad = 1'b1;
      end
      chk("blocked_write", {7'h00, bad}, 8'h00);
      rd(ADDR_STAT, v);
      chk("stat_done", v, 8'hC3);
      rd(ADDR_DATA, v);
      chk("rx_buffer", v, tx_byte);
      tick(2);
      chk("irq_clear", {7'h00, irq_out}, 8'h00);
      rd(ADDR_STAT, v);
      chk("stat_clear", v, 8'h03);
    end
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_STAT, 8'h07);
    wr(ADDR_CTRL, 8'h50);
    tick(3);
    chk("mosi_off", {7'h00, mosi_oe_n_out}, 8'h01);
    wr(ADDR_STAT, 8'h03);
    tick(3);
    chk("mosi_on", {7'h00, mosi_oe_n_out}, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'hD0);
    tick(2);
    sel_n_in <= 1'b0;
    tick(4);
    rd(ADDR_CTRL, v);
    chk("fault_ctrl", v, 8'h80);
    chk("fault_irq", {7'h00, irq_out}, 8'h01);
    rd(ADDR_STAT, v);
    chk("fault_stat", v, 8'h10);
    sel_n_in <= 1'b1;
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_STAT, v);
    chk("fault_clear", v, 8'h00);
    halt_in <= 1'b1;
    wr(ADDR_CTRL, 8'hC0);
    rd(ADDR_CTRL, v);
    chk("halt_frozen", v, 8'h00);
    halt_in <= 1'b0;
    tick(2);
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_CTRL, 8'h00);
      clock_polarity <= 1'($urandom);
      clock_phase <= j[0];
      tick(1);
      sck_in <= clock_polarity;
      wr(ADDR_STAT, 8'h02);
      wr(ADDR_CTRL, {4'hC, clock_polarity, clock_phase, 2'b00});
      tx_byte <= 8'($urandom);
      dat = 8'($urandom);
      tick(1);
      wr(ADDR_DATA, tx_byte);
      tick(2);
      chk("miso_drive", {7'h00, miso_oe_n_out}, 8'h00);
      sxfer(dat, v);
      chk("slave_tx", v, tx_byte);
      rd(ADDR_STAT, v);
      chk("slave_done", v, 8'h82);
      rd(ADDR_DATA, v);
      chk("slave_rx", v, dat);
      sxfer(~dat, v);
      chk("slave_echo", v, dat);
      sxfer(tx_byte, v);
      chk("slave_echo2", v, ~dat);
      chk("ovr_irq", {7'h00, irq_out}, 8'h01);
      rd(ADDR_STAT, v);
      chk("slave_ovr", v, 8'hA2);
      rd(ADDR_DATA, v);
      chk("ovr_keep", v, ~dat);
      halt_in <= 1'b1;
      sxfer(dat, v);
      chk("halt_echo", v, tx_byte);
      chk("halt_wake", {7'h00, wake_out}, 8'h01);
      halt_in <= 1'b0;
      rd(ADDR_STAT, v);
      chk("halt_stat", v, 8'h82);
      rd(ADDR_DATA, v);
      chk("halt_rx", v, dat);
      sxfer(8'h00, v);
      chk("dummy_echo", v, dat);
      rd(ADDR_STAT, v);
      rd(ADDR_DATA, v);
      chk("dummy_rx", v, 8'h00);
    end
    summarize();
  end
endmodule
